/* File: sscp_pkg.sv */
// Constants and carrier types of the synthesizer serial command port.
package sscp_pkg;

  localparam int CMD_W = 32;
  localparam int VAL_W = 64;
  localparam int FREQ_W = 24;
  localparam int SCALE_W = 4;
  localparam int ROUTE_W = 4;
  localparam int FREQ_LSB = 0;
  localparam int SCALE_LSB = 24;
  localparam int ROUTE_LSB = 28;
  localparam int MEM_AW = 3;

  localparam logic [5:0] SPI_BITS = 6'h20;
  localparam logic [5:0] SPI_CNT_MAX = 6'h3F;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  localparam logic [2:0] I2C_BYTES = 3'h5;
  localparam logic [2:0] I2C_DATA_BYTES = 3'h4;
  localparam int I2C_BITS_PER_CMD = 47;
  localparam logic [6:0] I2C_ADDR_DEF = 7'h48;

  localparam logic [ROUTE_W-1:0] RT_CHANNEL = 4'h0;
  localparam logic [ROUTE_W-1:0] RT_START = 4'h1;
  localparam logic [ROUTE_W-1:0] RT_STOP = 4'h2;
  localparam logic [ROUTE_W-1:0] RT_STEP = 4'h3;
  localparam logic [ROUTE_W-1:0] RT_REF = 4'h4;

  localparam logic [VAL_W-1:0] CHAN_RST = 64'h0000000000000000;
  localparam logic [VAL_W-1:0] START_RST = 64'h0000000000100000;
  localparam logic [VAL_W-1:0] STOP_RST = 64'h0000000000200000;
  localparam logic [VAL_W-1:0] STEP_RST = 64'h0000000000001000;
  localparam logic [VAL_W-1:0] REF_RST = 64'h0000000000010000;

  typedef struct packed {
    logic [ROUTE_W-1:0] route_code;
    logic [SCALE_W-1:0] decade_scale;
    logic [FREQ_W-1:0] freq_value;
  } sscp_cmd_t;

  typedef struct packed {
    logic clock_or_mode_strap;
    logic data_or_scl;
    logic select_or_sda;
  } sscp_pins_t;

  typedef enum logic [5:0] {
    I_IDLE = 6'h01,
    I_ADDR = 6'h02,
    I_DATA = 6'h04,
    I_ACK = 6'h08,
    I_WSTOP = 6'h10,
    I_SKIP = 6'h20
  } sscp_i2c_st_t;

  typedef enum logic [4:0] {
    C_IDLE = 5'h01,
    C_RD0 = 5'h02,
    C_RD1 = 5'h04,
    C_RD2 = 5'h08,
    C_RD3 = 5'h10
  } sscp_calc_st_t;

  typedef struct packed {
    sscp_pins_t meta;
    sscp_pins_t sync;
    sscp_pins_t prev;
    logic i2c_mode;
    logic [CMD_W-1:0] shift;
    logic [5:0] bit_cnt;
    sscp_i2c_st_t ist;
    logic [3:0] ibit;
    logic [2:0] ibyte;
    sscp_cmd_t word;
    logic [VAL_W-1:0] scaled;
    logic cmd_strobe;
    logic reserved_strobe;
    sscp_calc_st_t cst;
    logic [VAL_W-1:0] start_c;
    logic [VAL_W-1:0] chan_c;
    logic [VAL_W-1:0] freq;
    logic freq_valid;
    logic sda_out;
    logic sda_oe;
  } sscp_state_t;

endpackage

/* File: sscp_regmem.sv */
// Small register memory holding the channel, start, stop, step and reference values.
`timescale 1ns/100ps
`default_nettype none
module sscp_regmem #(
  parameter int W = 64,
  parameter int AW = 3,
  parameter logic [(2**AW)*W-1:0] RST_VALS = '0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  typedef struct packed {
    logic [2**AW-1:0][W-1:0] words;
    logic [W-1:0] rd;
  } sscp_mem_t;

  sscp_mem_t mem_r;
  sscp_mem_t mem_nxt;

  // Read data come from the old contents when a word is written and read together.
  always_comb
  begin
    mem_nxt = mem_r;
    mem_nxt.rd = mem_r.words[rd_addr];
    if (wr_en)
    begin
      mem_nxt.words[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_r <= {RST_VALS, {W{1'b0}}};
    end
    else if (ce)
    begin
      mem_r <= mem_nxt;
    end
  end

  assign rd_data = mem_r.rd;
endmodule
`default_nettype wire

/* File: sscp_top.sv */
// Serial command port of the synthesizer: pin decode, command latch and frequency.
`timescale 1ns/100ps
`default_nettype none
module sscp_top #(
  parameter logic [6:0] I2C_ADDR = sscp_pkg::I2C_ADDR_DEF,
  parameter logic [sscp_pkg::VAL_W-1:0] START_PRESET = sscp_pkg::START_RST,
  parameter logic [sscp_pkg::VAL_W-1:0] STOP_PRESET = sscp_pkg::STOP_RST,
  parameter logic [sscp_pkg::VAL_W-1:0] STEP_PRESET = sscp_pkg::STEP_RST,
  parameter logic [sscp_pkg::VAL_W-1:0] REF_PRESET = sscp_pkg::REF_RST
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic serial_pin_select_or_sda,
  input wire logic serial_pin_data_or_scl,
  input wire logic serial_pin_clock_or_mode_strap,
  output logic sda_out,
  output logic sda_oe,
  output logic i2c_mode,
  output sscp_pkg::sscp_cmd_t cmd_word,
  output logic cmd_strobe,
  output logic reserved_strobe,
  output logic [sscp_pkg::VAL_W-1:0] freq_hz,
  output logic freq_valid
);
  import sscp_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic route_ok(input logic [ROUTE_W-1:0] code);
    route_ok = (code <= RT_REF);
  endfunction

  function automatic logic [VAL_W-1:0] pow10(input logic [SCALE_W-1:0] n);
    case (n)
      4'h0: pow10 = 64'h0000000000000001;
      4'h1: pow10 = 64'h000000000000000A;
      4'h2: pow10 = 64'h0000000000000064;
      4'h3: pow10 = 64'h00000000000003E8;
      4'h4: pow10 = 64'h0000000000002710;
      4'h5: pow10 = 64'h00000000000186A0;
      4'h6: pow10 = 64'h00000000000F4240;
      4'h7: pow10 = 64'h0000000000989680;
      4'h8: pow10 = 64'h0000000005F5E100;
      4'h9: pow10 = 64'h000000003B9ACA00;
      4'hA: pow10 = 64'h00000002540BE400;
      4'hB: pow10 = 64'h000000174876E800;
      4'hC: pow10 = 64'h000000E8D4A51000;
      4'hD: pow10 = 64'h000009184E72A000;
      4'hE: pow10 = 64'h00005AF3107A4000;
      default: pow10 = 64'h00038D7EA4C68000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State and pin edges
  // ----------------------------------------------------------------
  sscp_state_t st_r;
  sscp_state_t st_nxt;
  sscp_pins_t pins;
  logic sda_s;
  logic scl_s;
  logic clk_s;
  logic clk_rise;
  logic cs_rise;
  logic cs_fall;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  logic spi_mode;
  logic spi_shift;
  logic commit;
  logic addr_hit;
  logic [5:0] cnt_base;
  logic mem_wr;
  logic [MEM_AW-1:0] mem_rd_addr;
  logic [VAL_W-1:0] mem_rd_data;

  assign pins = '{clock_or_mode_strap: serial_pin_clock_or_mode_strap,
                  data_or_scl: serial_pin_data_or_scl,
                  select_or_sda: serial_pin_select_or_sda};
  assign sda_s = st_r.sync.select_or_sda;
  assign scl_s = st_r.sync.data_or_scl;
  assign clk_s = st_r.sync.clock_or_mode_strap;
  assign clk_rise = clk_s && !st_r.prev.clock_or_mode_strap;
  assign cs_rise = sda_s && !st_r.prev.select_or_sda;
  assign cs_fall = !sda_s && st_r.prev.select_or_sda;
  assign scl_rise = scl_s && !st_r.prev.data_or_scl;
  assign scl_fall = !scl_s && st_r.prev.data_or_scl;
  assign i2c_start = scl_s && st_r.prev.data_or_scl && cs_fall;
  assign i2c_stop = scl_s && st_r.prev.data_or_scl && cs_rise;
  // A clock pin that ever rises is not strapped low, so the link is chip-select framed.
  assign spi_mode = !st_r.i2c_mode || clk_rise;
  assign spi_shift = spi_mode && !sda_s && clk_rise;
  assign addr_hit = (st_r.shift[7:1] == I2C_ADDR) && !st_r.shift[0];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.meta = pins;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
    st_nxt.cmd_strobe = 1'b0;
    st_nxt.reserved_strobe = 1'b0;
    st_nxt.freq_valid = 1'b0;
    commit = 1'b0;
    cnt_base = cs_fall ? 6'h00 : st_r.bit_cnt;
    mem_rd_addr = RT_START[MEM_AW-1:0];
    if (clk_rise)
    begin
      st_nxt.i2c_mode = 1'b0;
    end
    if (spi_mode)
    begin
      st_nxt.bit_cnt = cnt_base;
      if (spi_shift)
      begin
        st_nxt.shift = {st_r.shift[CMD_W-2:0], scl_s};
        if (cnt_base != SPI_CNT_MAX)
        begin
          st_nxt.bit_cnt = cnt_base + 6'h01;
        end
      end
      if (cs_rise && (st_r.bit_cnt == SPI_BITS))
      begin
        commit = 1'b1;
      end
    end
    else if (i2c_start)
    begin
      st_nxt.ist = I_ADDR;
      st_nxt.ibit = 4'h0;
      st_nxt.ibyte = 3'h0;
      st_nxt.sda_oe = 1'b0;
    end
    else if (i2c_stop)
    begin
      if (st_r.ist == I_WSTOP)
      begin
        commit = 1'b1;
      end
      st_nxt.ist = I_IDLE;
      st_nxt.sda_oe = 1'b0;
    end
    else
    begin
      case (st_r.ist)
        I_ADDR, I_DATA:
        begin
          if (scl_rise && (st_r.ibit != I2C_BYTE_BITS))
          begin
            st_nxt.shift = {st_r.shift[CMD_W-2:0], sda_s};
            st_nxt.ibit = st_r.ibit + 4'h1;
          end
          else if (scl_fall && (st_r.ibit == I2C_BYTE_BITS))
          begin
            if ((st_r.ist == I_DATA) || addr_hit)
            begin
              st_nxt.sda_oe = 1'b1;
              st_nxt.ist = I_ACK;
              if (st_r.ist == I_DATA)
              begin
                st_nxt.ibyte = st_r.ibyte + 3'h1;
              end
            end
            else
            begin
              st_nxt.ist = I_SKIP;
            end
          end
        end
        I_ACK:
        begin
          if (scl_fall)
          begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.ibit = 4'h0;
            st_nxt.ist = (st_r.ibyte == I2C_DATA_BYTES) ? I_WSTOP : I_DATA;
          end
        end
        I_WSTOP:
        begin
          // The STOP raises the clock too, so only a completed clock pulse voids the string.
          if (scl_fall)
          begin
            st_nxt.ist = I_SKIP;
          end
        end
        I_IDLE, I_SKIP: ;
        default:
        begin
          st_nxt.ist = I_IDLE;
          st_nxt.sda_oe = 1'b0;
        end
      endcase
    end
    if (commit)
    begin
      st_nxt.word = sscp_cmd_t'(st_r.shift);
      st_nxt.scaled = VAL_W'(st_r.shift[FREQ_LSB +: FREQ_W]
                      * pow10(st_r.shift[SCALE_LSB +: SCALE_W]));
      st_nxt.cmd_strobe = 1'b1;
      st_nxt.reserved_strobe = !route_ok(st_r.shift[ROUTE_LSB +: ROUTE_W]);
    end
    // Reads start, channel and step back one at a time, then forms the frequency.
    case (st_r.cst)
      C_RD0:
      begin
        mem_rd_addr = RT_START[MEM_AW-1:0];
        st_nxt.cst = C_RD1;
      end
      C_RD1:
      begin
        mem_rd_addr = RT_CHANNEL[MEM_AW-1:0];
        st_nxt.start_c = mem_rd_data;
        st_nxt.cst = C_RD2;
      end
      C_RD2:
      begin
        mem_rd_addr = RT_STEP[MEM_AW-1:0];
        st_nxt.chan_c = mem_rd_data;
        st_nxt.cst = C_RD3;
      end
      C_RD3:
      begin
        st_nxt.freq = VAL_W'(st_r.start_c + st_r.chan_c * mem_rd_data);
        st_nxt.freq_valid = 1'b1;
        st_nxt.cst = C_IDLE;
      end
      default:
      begin
        st_nxt.cst = C_IDLE;
      end
    endcase
    if (mem_wr)
    begin
      st_nxt.cst = C_RD0;
    end
  end

  // A stored command goes to the register its route code names.
  assign mem_wr = st_r.cmd_strobe && route_ok(st_r.word.route_code);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.meta <= '1;
      st_r.sync <= '1;
      st_r.prev <= '1;
      st_r.i2c_mode <= 1'b1;
      st_r.ist <= I_IDLE;
      st_r.cst <= C_RD0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register memory
  // ----------------------------------------------------------------
  sscp_regmem #(
    .W(VAL_W),
    .AW(MEM_AW),
    .RST_VALS({{3{CHAN_RST}}, REF_PRESET, STEP_PRESET, STOP_PRESET, START_PRESET,
               CHAN_RST})
  ) u_regmem (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .wr_en(mem_wr),
    .wr_addr(st_r.word.route_code[MEM_AW-1:0]),
    .wr_data(st_r.scaled),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  assign sda_out = st_r.sda_out;
  assign sda_oe = st_r.sda_oe;
  assign i2c_mode = st_r.i2c_mode;
  assign cmd_word = st_r.word;
  assign cmd_strobe = st_r.cmd_strobe;
  assign reserved_strobe = st_r.reserved_strobe;
  assign freq_hz = st_r.freq;
  assign freq_valid = st_r.freq_valid;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst || !ce);

  sequence s_spi_full;
    spi_mode && cs_rise && (st_r.bit_cnt == SPI_BITS);
  endsequence
  sequence s_i2c_done;
    !spi_mode && (st_r.ist == I_WSTOP) ##0 i2c_stop;
  endsequence
  sequence s_new_cmd;
    st_r.cmd_strobe && route_ok(st_r.word.route_code);
  endsequence

  a_ack_drive_only: assert property (st_r.sda_oe |-> st_r.i2c_mode && (st_r.ist == I_ACK)
                                     && !st_r.sda_out)
    else $error("SDA driven outside an acknowledge");
  a_spi_bit_count: assert property ((spi_shift && !cs_fall && (st_r.bit_cnt < SPI_BITS))
                                    |=> (st_r.bit_cnt == $past(st_r.bit_cnt) + 6'h01)
                                    && (st_r.shift[0] == $past(scl_s)))
    else $error("Chip-select bit not sampled on clock rise");
  a_cs_high_hold: assert property ((spi_mode && sda_s && clk_rise) |=> $stable(st_r.shift))
    else $error("Bit taken while select high");
  a_cs_word_latch: assert property (s_spi_full |=> st_r.cmd_strobe
                                    && (st_r.word == $past(st_r.shift)))
    else $error("Full word not latched on select rise");
  a_bad_len_drop: assert property ((spi_mode && cs_rise && (st_r.bit_cnt != SPI_BITS))
                                   |=> !st_r.cmd_strobe)
    else $error("Word of wrong length latched");
  a_stop_commit: assert property (s_i2c_done |=> st_r.cmd_strobe ##1 !st_r.cmd_strobe)
    else $error("STOP after five bytes did not apply data");
  a_start_purge: assert property ((!spi_mode && i2c_start) |=> (st_r.ist == I_ADDR)
                                  && !st_r.cmd_strobe && (st_r.ibyte == 3'h0))
    else $error("START did not discard the partial string");
  a_addr_filter: assert property ((!spi_mode && !i2c_start && !i2c_stop && scl_fall
                                  && (st_r.ist == I_ADDR) && (st_r.ibit == I2C_BYTE_BITS)
                                  && !addr_hit) |=> (st_r.ist == I_SKIP) && !st_r.sda_oe)
    else $error("Foreign address acknowledged");
  a_freq_follows: assert property (s_new_cmd |-> ##[5:40] st_r.freq_valid)
    else $error("Frequency not recomputed after a command");
  a_reserved_code: assert property ((st_r.cmd_strobe && !route_ok(st_r.word.route_code))
                                    |-> st_r.reserved_strobe && !mem_wr)
    else $error("Reserved route code wrote a register");
endmodule
`default_nettype wire

/* File: sscp_host.sv */
// Host processor model that drives the serial command pins in both link modes.
`timescale 1ns/100ps
`default_nettype none
module sscp_host (
  input wire logic mclk,
  input wire logic sda_oe,
  output logic pin_sel_sda,
  output logic pin_dat_scl,
  output logic pin_clk_strap
);
  logic sda_drv;

  // A released data line floats to the pull-up unless the block acknowledges.
  assign pin_sel_sda = sda_oe ? 1'b0 : sda_drv;

  initial
  begin
    sda_drv = 1'b1;
    pin_dat_scl = 1'b1;
    pin_clk_strap = 1'b0;
  end

  // --------------------------------------------------------------
  // Link phases of 80 ns give the 160 ns serial clock.
  // --------------------------------------------------------------
  task automatic half();
    repeat (20) @(negedge mclk);
  endtask

  task automatic i2c_start();
    sda_drv = 1'b1;
    half();
    pin_dat_scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    pin_dat_scl = 1'b0;
  endtask

  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_drv = b[i];
      half();
      pin_dat_scl = 1'b1;
      half();
      pin_dat_scl = 1'b0;
    end
    sda_drv = 1'b1;
    half();
    pin_dat_scl = 1'b1;
    half();
    ack = (pin_sel_sda === 1'b0);
    pin_dat_scl = 1'b0;
  endtask

  task automatic i2c_stop();
    sda_drv = 1'b0;
    half();
    pin_dat_scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask

  task automatic spi_frame(input logic [63:0] w, input int n);
    sda_drv = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      pin_dat_scl = w[i];
      half();
      pin_clk_strap = 1'b1;
      half();
      pin_clk_strap = 1'b0;
    end
    half();
    sda_drv = 1'b1;
    pin_dat_scl = ~pin_dat_scl;
    half();
    half();
  endtask

  // A clock pulse with select high leaves the two-wire mode and carries no bit.
  task automatic strap_pulse();
    pin_clk_strap = 1'b1;
    half();
    pin_clk_strap = 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

/* File: sscp_tb.sv */
// Self-checking bench of the synthesizer serial command port.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sscp_pkg::*;

  localparam logic [7:0] ADDR_WR = {I2C_ADDR_DEF, 1'b0};
  logic mclk, nrst, ce, sel_sda, dat_scl, clk_strap, sda_out, sda_oe, i2c_mode;
  logic cmd_strobe, reserved_strobe, freq_valid;
  sscp_cmd_t cmd_word;
  logic [VAL_W-1:0] freq_hz, m_start, m_chan, m_step;
  logic [31:0] rng, r;
  logic [3:0] rt;
  int miscompares, checks;
  sscp_cmd_t exp_cmd[$];
  logic exp_rsv[$];
  logic [VAL_W-1:0] exp_freq[$];

  sscp_top i_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .serial_pin_select_or_sda(sel_sda),
    .serial_pin_data_or_scl(dat_scl), .serial_pin_clock_or_mode_strap(clk_strap),
    .sda_out(sda_out), .sda_oe(sda_oe), .i2c_mode(i2c_mode), .cmd_word(cmd_word),
    .cmd_strobe(cmd_strobe), .reserved_strobe(reserved_strobe), .freq_hz(freq_hz),
    .freq_valid(freq_valid));

  sscp_host i_host (.mclk(mclk), .sda_oe(sda_oe), .pin_sel_sda(sel_sda),
    .pin_dat_scl(dat_scl), .pin_clk_strap(clk_strap));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Notes the latched word and, for a routed code, the frequency that follows.
  task automatic note(input sscp_cmd_t c);
    logic [VAL_W-1:0] v;
    v = VAL_W'(c.freq_value);
    repeat (c.decade_scale) v = v * 64'hA;
    exp_cmd.push_back(c);
    exp_rsv.push_back(c.route_code > RT_REF);
    case (c.route_code)
      RT_CHANNEL: m_chan = v;
      RT_START: m_start = v;
      RT_STEP: m_step = v;
      default: ;
    endcase
    if (c.route_code <= RT_REF)
      exp_freq.push_back(m_start + m_chan * m_step);
  endtask

  task automatic i2c_cmd(input logic [7:0] ab, input logic [31:0] w, input int nb, input bit fin);
    logic a;
    i_host.i2c_start();
    i_host.i2c_byte(ab, a);
    check(64'(a), 64'(ab == ADDR_WR));
    for (int k = 0; k < nb && a; k++)
    begin
      i_host.i2c_byte(w[31 - 8 * k -: 8], a);
      check(64'(a), 64'h1);
    end
    if (fin)
    begin
      if (nb == 4 && ab == ADDR_WR)
        note(w);
      i_host.i2c_stop();
    end
    repeat (40) @(negedge mclk);
  endtask

  task automatic spi_cmd(input logic [31:0] w, input int n);
    if (n == CMD_W)
      note(w);
    i_host.spi_frame({32'h0, w}, n);
    repeat (40) @(negedge mclk);
  endtask

  // --------------------------------------------------------------
  // Output watcher
  // --------------------------------------------------------------
  always @(negedge mclk)
  begin
    if (cmd_strobe === 1'b1)
    begin
      if (exp_cmd.size() == 0)
        check(64'h1, 64'h0);
      else
      begin
        check(64'(cmd_word), 64'(exp_cmd.pop_front()));
        check(64'(reserved_strobe), 64'(exp_rsv.pop_front()));
      end
    end
    if (sda_oe === 1'b1)
      check(64'(sda_out), 64'h0);
    if (freq_valid === 1'b1)
    begin
      if (exp_freq.size() == 0)
        check(64'h1, 64'h0);
      else
        check(freq_hz, exp_freq.pop_front());
    end
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    finish_test();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    rng = 32'h1;
    miscompares = 0;
    checks = 0;
    m_start = START_RST;
    m_chan = CHAN_RST;
    m_step = STEP_RST;
    exp_freq.push_back(START_RST);
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    repeat (20) @(negedge mclk);
    check(64'(i2c_mode), 64'h1);
    i2c_cmd(ADDR_WR, {RT_CHANNEL, 4'h0, 24'h000005}, 4, 1'b1);
    i2c_cmd({I2C_ADDR_DEF + 7'h1, 1'b0}, {RT_START, 4'h0, 24'h000007}, 4, 1'b1);
    i2c_cmd({I2C_ADDR_DEF, 1'b1}, {RT_START, 4'h0, 24'h000007}, 4, 1'b1);
    i2c_cmd(ADDR_WR, {RT_CHANNEL, 4'h0, 24'h000009}, 2, 1'b0);
    i2c_cmd(ADDR_WR, {RT_STEP, 4'h2, 24'h000003}, 4, 1'b1);
    i2c_cmd(ADDR_WR, {RT_CHANNEL, 4'h0, 24'h000009}, 3, 1'b1);
    i_host.strap_pulse();
    check(64'(i2c_mode), 64'h0);
    for (int k = 0; k < 6; k++)
    begin
      r = xs();
      rt = (k < 5) ? 4'(k) : 4'(32'h5 + r % 32'hB);
      spi_cmd({rt, 4'(r[27:24] % 4'h4), r[23:0]}, 32);
    end
    spi_cmd(xs(), 31);
    spi_cmd(xs(), 33);
    m_start = START_RST;
    m_chan = CHAN_RST;
    m_step = STEP_RST;
    exp_freq.push_back(START_RST);
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    repeat (20) @(negedge mclk);
    i2c_cmd(ADDR_WR, {RT_CHANNEL, 4'h1, 24'h000002}, 4, 1'b1);
    repeat (50) @(negedge mclk);
    check(64'(exp_cmd.size() + exp_freq.size()), 64'h0);
    finish_test();
  end
endmodule
`default_nettype wire
